/* core/smpm_pin_mux.sv */
/*
  Storage media pin mux: routes the shared media bus to the selected medium,
  falls back to gpio on unused lines, shares lines with sdram data, and sets
  the direction of the cpu high address port and the interrupt pin.
  Assumes configuration and controller signals come from ref_clk logic; all
  pin inputs are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
// Functional notes
// R01 - cpu high address port drives out with internal cpu, input with external cpu
// R02 - internal cpu mode: interrupt pin is input, forwarded as external interrupt
// R03 - external cpu mode: interrupt pin pulled low while internal interrupt pending
// R04 - one shared media bus; line function and direction follow selected medium
// R05 - lines unused by the selected medium serve as general purpose io
// R06 - small package: lines 19..8 unbonded, only modes on lines 7..0 usable
// R07 - sdram data shares media lines by package; accesses never overlap
// R08 - spi card clock supports mode 0 and mode 3 idle levels
// R09 - nand modes: data bit 0 on line 12, bits 1..7 on 13..19
// R10 - nand modes: write, read, protect strobes on 11,10,9; cle on 8
// R11 - nand mode: ale on 4, ready sampled on 1, chip enable on 0
// R12 - card nand mode: ready on 6, card detect on 5, chip enable on 2
// R13 - spi card: so 8, si 7, wp 6, rst 5, clk 4, ready 3, cs 2
// R14 - sd mode: data 3..0 on lines 11..8, clock on 3, command on 2
// R15 - cf memory: address 1,0,2 on 12,11,13; oe 10, we 9, rst 8, reg 3, ce 2
// R16 - both cf modes: data 0..5 on 14..19; rdy 7, wait 6, detects 5 and 4
// R17 - cf ide: read 10, write 9, cs2 on 3, cs1 on 2; rest as memory mode
// R18 - serial flash: clock on line 0, bidirectional data on line 1
// R19 - nor flash: address 17..8 on lines 12..3, 18..21 on 13..16
// R20 - nor flash: reset on 2, ready sampled on 1, chip enable on 0
// R21 - configuration selects exactly one medium and the cpu mode
// R22 - input lines have drivers off; bidirectional lines follow transfer direction
module smpm_pin_mux
  import smpm_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // configuration
  input  wire smpm_media_e       media_sel,
  input  wire logic              cpu_ext_mode,
  input  wire logic              pkg_small,
  input  wire logic              spi_mode3,
  // media controller side
  input  wire smpm_ctl_s         media_ctl,
  input  wire logic              media_req,
  output smpm_min_s              media_in,
  output logic                   media_gnt,
  output smpm_media_e            media_act,
  // general purpose io on unused lines
  input  wire logic [LOG_W-1:0]  gpio_out,
  input  wire logic [LOG_W-1:0]  gpio_oe,
  output logic      [LOG_W-1:0]  gpio_in,
  // sdram data side
  input  wire logic              sdram_req,
  input  wire logic [MD_W-1:0]   sdram_dout,
  input  wire logic              sdram_doe,
  output logic                   sdram_gnt,
  output logic      [MD_W-1:0]   sdram_din,
  // cpu port and interrupts
  input  wire logic [CPU_W-1:0]  cpu_addr_hi,
  input  wire logic              core_irq,
  output logic      [CPU_W-1:0]  cpu_addr_hi_ext,
  output logic                   ext_irq_to_cpu,
  // media bus pins
  input  wire logic [FM_PINS-1:0] fm_pin_in,
  output logic      [FM_PINS-1:0] fm_pin_out,
  output logic      [FM_PINS-1:0] fm_pin_oe,
  // sdram data pins
  input  wire logic [MD_W-1:0]   md_pin_in,
  output logic      [MD_W-1:0]   md_pin_out,
  output logic      [MD_W-1:0]   md_pin_oe,
  // cpu high address port and interrupt pin
  input  wire logic [CPU_W-1:0]  cpu_high_addr_port_in,
  output logic      [CPU_W-1:0]  cpu_high_addr_port_out,
  output logic      [CPU_W-1:0]  cpu_high_addr_port_oe,
  input  wire logic              irq_pin_in,
  output logic                   irq_pin_out,
  output logic                   irq_pin_oe
);

  localparam int SYNC_W = FM_PINS + MD_W + CPU_W + 1;

  logic [SYNC_W-1:0]  sync_bus;
  logic [FM_PINS-1:0] fm_sync;
  logic [MD_W-1:0]    md_sync;
  logic [CPU_W-1:0]   cpu_sync;
  logic               irq_sync;

  smpm_sync #(
    .W (SYNC_W)
  ) u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in ({fm_pin_in, md_pin_in, cpu_high_addr_port_in, irq_pin_in}),
    .sync_out (sync_bus)
  );

  assign {fm_sync, md_sync, cpu_sync, irq_sync} = sync_bus;

  smpm_media_e        mode;
  smpm_own_e          own_ff;
  smpm_own_e          nxt_own;
  logic [LOG_W-1:0]   log_in;
  logic [LOG_W-1:0]   lo;
  logic [LOG_W-1:0]   le;
  smpm_min_s          nxt_min;
  logic               spi_sck;

  // unknown codes select no medium, so exactly one placement is ever active
  always_comb
  begin
    case (media_sel)
      MED_NONE, MED_NAND, MED_SMC, MED_SPI, MED_SD,
      MED_CFMEM, MED_CFIDE, MED_SFL, MED_NOR: mode = media_sel; // [R21]
      default: mode = MED_NONE;
    endcase
    // only serial flash fits the bonded low lines of the small package
    if (pkg_small && (mode != MED_SFL))
      mode = MED_NONE; // [R06]
  end

  // idle level of the clock between frames selects mode 0 or mode 3
  assign spi_sck = media_ctl.ce_n ? spi_mode3 : media_ctl.sclk; // [R08]

  // logical line inputs, gathered from the bonded pins of this package
  always_comb
  begin
    log_in = '0;
    for (int k = 0; k < FM_PINS; k++)
    begin
      if (pkg_small && (k >= SMALL_BOND))
        log_in[k] = md_sync[k - SMALL_MD_BASE]; // [R07]
      else
        log_in[k] = fm_sync[k];
    end
    if (!pkg_small)
    begin
      for (int k = 0; k < LARGE_MD_CNT; k++)
        log_in[LARGE_MD_BASE + k] = md_sync[k]; // [R07]
    end
  end

  // per-medium placement; gpio keeps every line the medium leaves free
  always_comb
  begin
    lo = gpio_out; // [R05]
    le = gpio_oe; // [R05]
    nxt_min = '0;
    case (mode) // [R04]
      MED_NAND, MED_SMC:
      begin
        for (int i = 0; i < NAND_DW; i++)
        begin
          lo[NAND_D0 + i] = media_ctl.dout[i]; // [R09]
          le[NAND_D0 + i] = media_ctl.doe; // [R22]
          nxt_min.din[i] = log_in[NAND_D0 + i];
        end
        lo[NAND_WE] = media_ctl.wr_n; // [R10]
        le[NAND_WE] = 1'b1;
        lo[NAND_RE] = media_ctl.rd_n; // [R10]
        le[NAND_RE] = 1'b1;
        lo[NAND_WP] = media_ctl.wp_n; // [R10]
        le[NAND_WP] = 1'b1;
        lo[NAND_CLE] = media_ctl.cle; // [R10]
        le[NAND_CLE] = 1'b1;
        lo[NAND_ALE] = media_ctl.ale; // [R11]
        le[NAND_ALE] = 1'b1;
        if (mode == MED_NAND)
        begin
          le[NAND_RDY] = 1'b0; // [R22]
          nxt_min.rdy = log_in[NAND_RDY]; // [R11]
          lo[NAND_CE] = media_ctl.ce_n; // [R11]
          le[NAND_CE] = 1'b1;
        end
        else
        begin
          le[SMC_RDY] = 1'b0;
          nxt_min.rdy = log_in[SMC_RDY]; // [R12]
          le[SMC_CD1] = 1'b0;
          nxt_min.cd1 = log_in[SMC_CD1]; // [R12]
          lo[SMC_CE] = media_ctl.ce_n; // [R12]
          le[SMC_CE] = 1'b1;
        end
      end
      MED_SPI:
      begin
        lo[SPI_SO] = media_ctl.sdo; // [R13]
        le[SPI_SO] = 1'b1;
        le[SPI_SI] = 1'b0; // [R22]
        nxt_min.sdi = log_in[SPI_SI]; // [R13]
        lo[SPI_WP] = media_ctl.wp_n; // [R13]
        le[SPI_WP] = 1'b1;
        lo[SPI_RST] = media_ctl.rst_n; // [R13]
        le[SPI_RST] = 1'b1;
        lo[SPI_SCK] = spi_sck; // [R13]
        le[SPI_SCK] = 1'b1;
        le[SPI_RDY] = 1'b0;
        nxt_min.rdy = log_in[SPI_RDY]; // [R13]
        lo[SPI_CS] = media_ctl.ce_n; // [R13]
        le[SPI_CS] = 1'b1;
      end
      MED_SD:
      begin
        for (int i = 0; i < SD_DW; i++)
        begin
          lo[SD_D0 + i] = media_ctl.dout[i]; // [R14]
          le[SD_D0 + i] = media_ctl.doe; // [R22]
          nxt_min.din[i] = log_in[SD_D0 + i];
        end
        lo[SD_CLK] = media_ctl.sclk; // [R14]
        le[SD_CLK] = 1'b1;
        lo[SD_CMD] = media_ctl.cmd_out; // [R14]
        le[SD_CMD] = media_ctl.cmd_oe; // [R22]
        nxt_min.cmd_in = log_in[SD_CMD];
      end
      MED_CFMEM, MED_CFIDE:
      begin
        lo[CF_A0] = media_ctl.addr[0]; // [R15]
        lo[CF_A1] = media_ctl.addr[1]; // [R15]
        lo[CF_A2] = media_ctl.addr[2]; // [R15]
        lo[CF_RD] = media_ctl.rd_n; // [R17]
        lo[CF_WR] = media_ctl.wr_n; // [R17]
        lo[CF_RST] = media_ctl.rst_n; // [R15]
        lo[CF_CS2] = media_ctl.ce2_n; // [R17]
        lo[CF_CS1] = media_ctl.ce_n; // [R15]
        le[CF_A0] = 1'b1;
        le[CF_A1] = 1'b1;
        le[CF_A2] = 1'b1;
        le[CF_RD] = 1'b1;
        le[CF_WR] = 1'b1;
        le[CF_RST] = 1'b1;
        le[CF_CS2] = 1'b1;
        le[CF_CS1] = 1'b1;
        for (int i = 0; i < CF_DW; i++)
        begin
          lo[CF_D0 + i] = media_ctl.dout[i]; // [R16]
          le[CF_D0 + i] = media_ctl.doe; // [R22]
          nxt_min.din[i] = log_in[CF_D0 + i];
        end
        le[CF_RDY] = 1'b0; // [R22]
        le[CF_WAIT] = 1'b0;
        le[CF_CD1] = 1'b0;
        le[CF_CD2] = 1'b0;
        nxt_min.rdy = log_in[CF_RDY]; // [R16]
        nxt_min.wait_n = log_in[CF_WAIT]; // [R16]
        nxt_min.cd1 = log_in[CF_CD1]; // [R16]
        nxt_min.cd2 = log_in[CF_CD2]; // [R16]
      end
      MED_SFL:
      begin
        lo[SFL_SCK] = media_ctl.sclk; // [R18]
        le[SFL_SCK] = 1'b1;
        lo[SFL_SIO] = media_ctl.sdo; // [R18]
        le[SFL_SIO] = media_ctl.doe; // [R22]
        nxt_min.sdi = log_in[SFL_SIO];
      end
      MED_NOR:
      begin
        for (int k = 0; k < NOR_AW; k++)
        begin
          lo[NOR_A_LINE + k] = media_ctl.addr[NOR_ADDR_LO + k]; // [R19]
          le[NOR_A_LINE + k] = 1'b1;
        end
        lo[NOR_RST] = media_ctl.rst_n; // [R20]
        le[NOR_RST] = 1'b1;
        le[NOR_RDY] = 1'b0; // [R22]
        nxt_min.rdy = log_in[NOR_RDY]; // [R20]
        lo[NOR_CE] = media_ctl.ce_n; // [R20]
        le[NOR_CE] = 1'b1;
      end
      default:
      begin
        lo = gpio_out;
        le = gpio_oe;
      end
    endcase
  end

  // shared lines change owner only through an idle cycle with all drivers off
  always_comb
  begin
    nxt_own = own_ff;
    case (own_ff)
      OWN_IDLE:
      begin
        if (sdram_req)
          nxt_own = OWN_SDRAM; // [R07]
        else if (media_req)
          nxt_own = OWN_MEDIA;
      end
      OWN_SDRAM:
        if (!sdram_req)
          nxt_own = OWN_IDLE; // [R07]
      OWN_MEDIA:
        if (!media_req)
          nxt_own = OWN_IDLE; // [R07]
      default: nxt_own = OWN_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      own_ff <= OWN_IDLE;
      sdram_gnt <= 1'b0;
      media_gnt <= 1'b0;
    end
    else
    begin
      own_ff <= nxt_own;
      sdram_gnt <= (nxt_own == OWN_SDRAM);
      media_gnt <= (nxt_own == OWN_MEDIA);
    end
  end

  // media bus pins; unbonded lines of the small package are never driven
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      fm_pin_out <= '0;
      fm_pin_oe <= '0;
    end
    else
    begin
      for (int k = 0; k < FM_PINS; k++)
      begin
        fm_pin_out[k] <= lo[k];
        fm_pin_oe[k] <= le[k] && !(pkg_small && (k >= SMALL_BOND)); // [R06]
      end
    end
  end

  // sdram data pins carry shared media lines only while media owns them
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      md_pin_out <= '0;
      md_pin_oe <= '0;
    end
    else
    begin
      for (int i = 0; i < MD_W; i++)
      begin
        md_pin_out[i] <= sdram_dout[i];
        md_pin_oe[i] <= (nxt_own == OWN_SDRAM) && sdram_doe; // [R07]
        if (pkg_small && (i < SMALL_MD_CNT) && (nxt_own == OWN_MEDIA))
        begin
          md_pin_out[i] <= lo[SMALL_MD_BASE + i]; // [R07]
          md_pin_oe[i] <= le[SMALL_MD_BASE + i];
        end
        if (!pkg_small && (i < LARGE_MD_CNT) && (nxt_own == OWN_MEDIA))
        begin
          md_pin_out[i] <= lo[LARGE_MD_BASE + i]; // [R07]
          md_pin_oe[i] <= le[LARGE_MD_BASE + i];
        end
      end
    end
  end

  // sampled values toward the controllers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      media_in <= '0;
      media_act <= MED_NONE;
      gpio_in <= '0;
      sdram_din <= '0;
    end
    else
    begin
      media_in <= nxt_min;
      media_act <= mode;
      gpio_in <= log_in;
      sdram_din <= md_sync;
    end
  end

  // cpu port and interrupt pin direction follow the processor mode
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cpu_high_addr_port_out <= '0;
      cpu_high_addr_port_oe <= '0;
      cpu_addr_hi_ext <= '0;
      irq_pin_out <= 1'b0;
      irq_pin_oe <= 1'b0;
      ext_irq_to_cpu <= 1'b0;
    end
    else
    begin
      cpu_high_addr_port_out <= cpu_addr_hi; // [R01]
      cpu_high_addr_port_oe <= {CPU_W{!cpu_ext_mode}}; // [R01]
      cpu_addr_hi_ext <= cpu_ext_mode ? cpu_sync : '0; // [R01]
      irq_pin_out <= 1'b0;
      // open-drain style: only ever pulls the pin low
      irq_pin_oe <= cpu_ext_mode && core_irq; // [R03]
      ext_irq_to_cpu <= !cpu_ext_mode && !irq_sync; // [R02]
    end
  end

endmodule

/* shared/smpm_pkg.sv */
/*
  Constants, line positions and carrier types for the storage media pin mux.
  Assumes a single ref_clk domain; the pin level is resolved by the testbench.
*/
package smpm_pkg;

  // bus sizes and package-dependent sharing with the sdram data pins
  localparam int FM_PINS   = 20;
  localparam int LOG_W     = 30;
  localparam int MD_W      = 16;
  localparam int CPU_W     = 8;
  localparam int SMALL_BOND = 8;
  localparam int SMALL_MD_BASE = 8;
  localparam int SMALL_MD_CNT  = 12;
  localparam int LARGE_MD_BASE = 20;
  localparam int LARGE_MD_CNT  = 10;

  // nand and removable nand card
  localparam int NAND_D0 = 12, NAND_WE = 11, NAND_RE = 10, NAND_WP = 9, NAND_CLE = 8;
  localparam int NAND_ALE = 4, NAND_RDY = 1, NAND_CE = 0;
  localparam int SMC_RDY = 6, SMC_CD1 = 5, SMC_CE = 2;
  localparam int NAND_DW = 8;

  // card in spi mode
  localparam int SPI_SO = 8, SPI_SI = 7, SPI_WP = 6, SPI_RST = 5, SPI_SCK = 4;
  localparam int SPI_RDY = 3, SPI_CS = 2;

  // sd card
  localparam int SD_D0 = 8, SD_CLK = 3, SD_CMD = 2, SD_DW = 4;

  // compactflash, memory and ide modes share one placement
  localparam int CF_A0 = 11, CF_A1 = 12, CF_A2 = 13, CF_RD = 10, CF_WR = 9, CF_RST = 8;
  localparam int CF_RDY = 7, CF_WAIT = 6, CF_CD1 = 5, CF_CD2 = 4, CF_CS2 = 3, CF_CS1 = 2;
  localparam int CF_D0 = 14, CF_DW = 6;

  // serial flash
  localparam int SFL_SCK = 0, SFL_SIO = 1;

  // nor flash: address bit ADDR_LO+k sits on line NOR_A_LINE+k
  localparam int NOR_A_LINE = 3, NOR_ADDR_LO = 8, NOR_AW = 14;
  localparam int NOR_RST = 2, NOR_RDY = 1, NOR_CE = 0;
  localparam int ADDR_W = 22;

  typedef enum logic [3:0] {
    MED_NONE  = 4'h0,
    MED_NAND  = 4'h1,
    MED_SMC   = 4'h2,
    MED_SPI   = 4'h3,
    MED_SD    = 4'h4,
    MED_CFMEM = 4'h5,
    MED_CFIDE = 4'h6,
    MED_SFL   = 4'h7,
    MED_NOR   = 4'h8
  } smpm_media_e;

  typedef enum logic [1:0] {
    OWN_IDLE  = 2'h0,
    OWN_SDRAM = 2'h1,
    OWN_MEDIA = 2'h2
  } smpm_own_e;

  // signals from the media controller toward the pins
  typedef struct packed {
    logic [7:0]        dout;
    logic              doe;
    logic [ADDR_W-1:0] addr;
    logic              wr_n;
    logic              rd_n;
    logic              wp_n;
    logic              cle;
    logic              ale;
    logic              ce_n;
    logic              ce2_n;
    logic              rst_n;
    logic              sclk;
    logic              sdo;
    logic              cmd_out;
    logic              cmd_oe;
  } smpm_ctl_s;

  // signals sampled from the pins for the media controller
  typedef struct packed {
    logic [7:0] din;
    logic       rdy;
    logic       cd1;
    logic       cd2;
    logic       wait_n;
    logic       sdi;
    logic       cmd_in;
  } smpm_min_s;

endpackage

/* core/smpm_sync.sv */
/*
  Two-stage synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to ref_clk and reset is synchronous.
*/
`timescale 1ns/1ps
module smpm_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // asynchronous in, synchronised out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // the first stage feeds only the second stage
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

/* verification/smpm_pin_mux_props.sv */
/*
  Concurrent checks on the ports of the storage media pin mux.
  Assumes it is bound into smpm_pin_mux with a single ref_clk domain.
*/
`timescale 1ns/1ps
module smpm_pin_mux_props
  import smpm_pkg::*;
(
  // clock and reset
  input logic               ref_clk,
  input logic               sys_rst,
  // configuration and requests
  input smpm_media_e        media_sel,
  input logic               cpu_ext_mode,
  input logic               pkg_small,
  input logic               spi_mode3,
  input smpm_ctl_s          media_ctl,
  input logic               sdram_req,
  input logic               core_irq,
  // results
  input logic               media_gnt,
  input logic               sdram_gnt,
  input smpm_media_e        media_act,
  input logic [CPU_W-1:0]   cpu_addr_hi_ext,
  input logic               ext_irq_to_cpu,
  // pins
  input logic [FM_PINS-1:0] fm_pin_out,
  input logic [FM_PINS-1:0] fm_pin_oe,
  input logic [CPU_W-1:0]   cpu_high_addr_port_in,
  input logic [CPU_W-1:0]   cpu_high_addr_port_oe,
  input logic               irq_pin_in,
  input logic               irq_pin_out,
  input logic               irq_pin_oe
);
  logic rst_d_ff;

  // past values from inside reset are not trusted at the first edge after it
  always_ff @(posedge ref_clk) rst_d_ff <= sys_rst;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence in_mode(smpm_media_e m);
    !rst_d_ff && $past(media_sel) == m && !$past(pkg_small);
  endsequence

  sequence both_idle;
    !sdram_gnt && !media_gnt;
  endsequence

  cpu_port_dir_a: assert property (
    !rst_d_ff |-> cpu_high_addr_port_oe == {CPU_W{!$past(cpu_ext_mode)}}) else $error("port dir");
  addr_capture_a: assert property (
    cpu_ext_mode [*4] |=> cpu_addr_hi_ext == $past(cpu_high_addr_port_in, 3))
    else $error("port capture");
  irq_forward_a: assert property (
    (!cpu_ext_mode && !irq_pin_in) [*4] |=> ext_irq_to_cpu) else $error("irq forward");
  irq_drive_a: assert property (
    !rst_d_ff |-> irq_pin_oe == $past(cpu_ext_mode && core_irq) && !irq_pin_out)
    else $error("irq drive");
  nand_map_a: assert property (
    in_mode(MED_NAND) |-> fm_pin_out[NAND_WE] == $past(media_ctl.wr_n) && !fm_pin_oe[NAND_RDY]
    && fm_pin_out[NAND_ALE] == $past(media_ctl.ale) && fm_pin_oe[19:12] == {8{$past(media_ctl.doe)}})
    else $error("nand map");
  spi_idle_a: assert property (
    in_mode(MED_SPI) ##0 $past(media_ctl.ce_n) |-> fm_pin_out[SPI_SCK] == $past(spi_mode3))
    else $error("spi clock idle");
  nor_map_a: assert property (
    in_mode(MED_NOR) |-> fm_pin_out[16:3] == $past(media_ctl.addr[21:8])
    && fm_pin_out[NOR_CE] == $past(media_ctl.ce_n)) else $error("nor map");
  small_pkg_a: assert property (
    pkg_small [*3] |=> fm_pin_oe[19:8] == 12'h000 && media_act inside {MED_NONE, MED_SFL})
    else $error("small package");
  arb_gap_a: assert property (
    (sdram_gnt |=> !media_gnt) and (media_gnt |=> !sdram_gnt)) else $error("handover gap");
  arb_first_a: assert property (
    both_idle ##0 sdram_req |=> sdram_gnt && !media_gnt) else $error("sdram grant");
endmodule

/* verification/smpm_media_model.sv */
/*
  Behavioural storage device on the media bus for the medium in use.
  Assumes ref_clk from the bench; released lines the device does not drive show the inverse level.
*/
`timescale 1ns/1ps
module smpm_media_model
  import smpm_pkg::*;
(
  // clock
  input  logic               ref_clk,
  // medium and device levels
  input  smpm_media_e        media_act,
  input  logic [FM_PINS-1:0] dev_val,
  // media bus pins
  input  logic [FM_PINS-1:0] fm_pin_out,
  input  logic [FM_PINS-1:0] fm_pin_oe,
  output logic [FM_PINS-1:0] fm_pin_in
);
  logic [FM_PINS-1:0] dev_drv;
  logic [FM_PINS-1:0] last_ff = '0;

  // data lines only win where the mux has let go of them
  always_comb
  begin
    case (media_act)
      MED_NAND:  dev_drv = 20'hff002;
      MED_SMC:   dev_drv = 20'hff060;
      MED_SPI:   dev_drv = 20'h00088;
      MED_SD:    dev_drv = 20'h00f04;
      MED_CFMEM,
      MED_CFIDE: dev_drv = 20'hfc0f0;
      MED_SFL,
      MED_NOR:   dev_drv = 20'h00002;
      default:   dev_drv = 20'h00000;
    endcase
  end

  // a floating line must not look like it kept its last level
  assign fm_pin_in = (fm_pin_oe & fm_pin_out) | (~fm_pin_oe & dev_drv & dev_val)
                   | (~fm_pin_oe & ~dev_drv & ~last_ff);

  // remember only what was last driven, so a released line settles at its inverse
  always @(posedge ref_clk) last_ff <= (fm_pin_oe & fm_pin_out) | (~fm_pin_oe & last_ff);
endmodule

/* verification/tb_top.sv */
/*
  Self-checking bench for the storage media pin mux and a storage device model.
  Assumes the checker and the device model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end

module tb_top
  import smpm_pkg::*;
;
  logic               ref_clk = 1'b0;
  logic               sys_rst = 1'b1;
  smpm_media_e        media_sel, media_act;
  smpm_ctl_s          media_ctl;
  smpm_min_s          media_in;
  logic               cpu_ext_mode, pkg_small, spi_mode3, media_req, media_gnt, core_irq;
  logic               sdram_req, sdram_doe, sdram_gnt, ext_irq_to_cpu, irq_drv;
  logic               irq_pin_in, irq_pin_out, irq_pin_oe;
  logic [LOG_W-1:0]   gpio_out, gpio_oe, gpio_in;
  logic [MD_W-1:0]    sdram_dout, sdram_din, md_pin_in, md_pin_out, md_pin_oe, md_drv;
  logic [CPU_W-1:0]   cpu_addr_hi, cpu_addr_hi_ext, port_drv;
  logic [CPU_W-1:0]   cpu_high_addr_port_in, cpu_high_addr_port_out, cpu_high_addr_port_oe;
  logic [FM_PINS-1:0] fm_pin_in, fm_pin_out, fm_pin_oe, dev_val;
  logic [31:0]        seed = 32'hb52b;
  logic [31:0]        r;
  int                 err_count = 0, tests_run = 0, cyc = 0, ri;
  localparam int      CTL_W = $bits(smpm_ctl_s);

  always #10 ref_clk = ~ref_clk;

  assign md_pin_in = (md_pin_oe & md_pin_out) | (~md_pin_oe & md_drv);
  assign cpu_high_addr_port_in = (cpu_high_addr_port_oe & cpu_high_addr_port_out)
                               | (~cpu_high_addr_port_oe & port_drv);
  assign irq_pin_in = irq_pin_oe ? irq_pin_out : irq_drv;

  smpm_pin_mux dut (.*);

  smpm_media_model u_dev (.ref_clk(ref_clk), .media_act(media_act), .dev_val(dev_val),
                          .fm_pin_out(fm_pin_out), .fm_pin_oe(fm_pin_oe), .fm_pin_in(fm_pin_in));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int rdy_line(smpm_media_e m);
    case (m)
      MED_NAND:             return NAND_RDY;
      MED_NOR:              return NOR_RDY;
      MED_SMC:              return SMC_RDY;
      MED_SPI:              return SPI_RDY;
      MED_CFMEM, MED_CFIDE: return CF_RDY;
      default:              return -1;
    endcase
  endfunction

  function automatic logic [7:0] din_exp(smpm_media_e m, smpm_ctl_s c, logic [19:0] v);
    logic [7:0] w;
    logic [7:0] d;
    case (m)
      MED_NAND, MED_SMC:    {w, d} = {8'hff, v[19:12]};
      MED_SD:               {w, d} = {8'h0f, 4'h0, v[11:8]};
      MED_CFMEM, MED_CFIDE: {w, d} = {8'h3f, 2'h0, v[19:14]};
      default:              {w, d} = 16'h0000;
    endcase
    return c.doe ? c.dout & w : d;
  endfunction

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // the whole sequence needs well under 2000 cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      finish_test();
    end
  end

  initial
  begin
    {cpu_ext_mode, pkg_small, spi_mode3, media_req, sdram_req, sdram_doe, core_irq} = '0;
    {irq_drv, gpio_out, gpio_oe, sdram_dout, md_drv, cpu_addr_hi, port_drv, dev_val} = '0;
    media_sel = MED_NONE;
    media_ctl = '0;
    step(6);
    sys_rst = 1'b0;
    step(1);
    `CHK("act_rst", MED_NONE, media_act)
    for (int e = 0; e < 2; e++)
    begin
      cpu_ext_mode = e[0];
      core_irq = 1'b1;
      {port_drv, cpu_addr_hi} = 16'(rnd());
      step(4);
      `CHK("port_oe", {CPU_W{~e[0]}}, cpu_high_addr_port_oe)
      `CHK("addr_ext", e[0] ? port_drv : 8'h00, cpu_addr_hi_ext)
      `CHK("irq_fwd", ~e[0], ext_irq_to_cpu)
      `CHK("irq_oe", e[0], irq_pin_oe)
      `CHK("port_out", cpu_addr_hi, cpu_high_addr_port_out)
    end
    cpu_ext_mode = 1'b0;
    gpio_oe = '1;
    for (int m = 0; m < 9; m++)
    begin
      media_sel = smpm_media_e'(m);
      media_ctl = CTL_W'({rnd(), rnd()});
      gpio_out = LOG_W'(rnd());
      dev_val = FM_PINS'(rnd());
      step(5);
      ri = rdy_line(media_sel);
      `CHK("act", media_sel, media_act)
      `CHK("din", din_exp(media_sel, media_ctl, dev_val), media_in.din)
      if (ri >= 0) `CHK("rdy", dev_val[ri], media_in.rdy)
      case (media_sel)
        MED_NONE:
        begin
          `CHK("gpio", gpio_out[19:0], fm_pin_out)
          `CHK("gpio_in", {10'h000, gpio_out[19:0]}, gpio_in)
        end
        MED_NAND:
        begin
          `CHK("we", media_ctl.wr_n, fm_pin_out[NAND_WE])
          `CHK("ce", media_ctl.ce_n, fm_pin_out[NAND_CE])
          `CHK("free", gpio_out[2], fm_pin_out[2])
          `CHK("rdy_oe", 1'b0, fm_pin_oe[NAND_RDY])
        end
        MED_SMC: `CHK("cd1", dev_val[SMC_CD1], media_in.cd1)
        MED_SPI: `CHK("so", media_ctl.sdo, fm_pin_out[SPI_SO])
        MED_SD: `CHK("clk", media_ctl.sclk, fm_pin_out[SD_CLK])
        MED_CFMEM: `CHK("addr", media_ctl.addr[2:0], fm_pin_out[13:11])
        MED_CFIDE: `CHK("rd", media_ctl.rd_n, fm_pin_out[CF_RD])
        MED_SFL: `CHK("sck", media_ctl.sclk, fm_pin_out[SFL_SCK])
        default: `CHK("nor", media_ctl.addr[21:8], fm_pin_out[16:3])
      endcase
    end
    media_sel = MED_SPI;
    media_ctl.ce_n = 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      spi_mode3 = s[0];
      step(2);
      `CHK("sck_idle", s[0], fm_pin_out[SPI_SCK])
    end
    pkg_small = 1'b1;
    media_sel = MED_NAND;
    step(3);
    `CHK("small", MED_NONE, media_act)
    `CHK("hi_oe", 12'h000, fm_pin_oe[19:8])
    media_sel = MED_SFL;
    sdram_dout = 16'(rnd());
    {sdram_doe, sdram_req, media_req} = 3'b111;
    step(1);
    `CHK("sgnt", 2'b10, {sdram_gnt, media_gnt})
    `CHK("md_oe", 16'hffff, md_pin_oe)
    `CHK("md_out", sdram_dout, md_pin_out)
    sdram_req = 1'b0;
    step(1);
    `CHK("idle", 2'b00, {sdram_gnt, media_gnt})
    step(1);
    `CHK("mgnt", 2'b01, {sdram_gnt, media_gnt})
    `CHK("md_hi", 4'h0, md_pin_oe[15:12])
    `CHK("act_sfl", MED_SFL, media_act)
    step(1);
    `CHK("sd_din", sdram_dout, sdram_din)
    for (int i = 0; i < 400; i++)
    begin
      r = rnd();
      if (i % 8 == 0)
      begin
        {cpu_ext_mode, pkg_small, spi_mode3} = r[2:0];
        media_sel = smpm_media_e'(r[6:3] % 4'd9);
      end
      {media_req, sdram_req, sdram_doe, core_irq, irq_drv} = r[11:7];
      media_ctl = CTL_W'({r, rnd()});
      {sdram_dout, md_drv} = rnd();
      {port_drv, cpu_addr_hi} = r[31:16];
      {gpio_out, dev_val} = {rnd(), rnd()};
      step(1);
    end
    finish_test();
  end
endmodule

bind smpm_pin_mux smpm_pin_mux_props u_props (.*);
